// ==== src/sodfj_core.sv ====
// Purpose: scalar operand decode and fork/join sequencer, one wavefront
// Assumes: AHB-Lite slave, 40 MHz hclk, aperture words from same clock
// Notes:   every command completes on the edge ending its write
//
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module sodfj_core
   import sodfj_pkg::*;
(
   input  wire logic         hclk,      // core clock
   input  wire logic         hresetn,   // async reset, active low
   input  wire logic         ce,        // clock enable, freezes state
   input  wire logic         hsel,      // slave select
   input  wire logic [31:0]  haddr,     // byte address
   input  wire logic [1:0]   htrans,    // transfer type
   input  wire logic         hwrite,    // write not read
   input  wire logic [2:0]   hsize,     // transfer size, word only
   input  wire logic [31:0]  hwdata,    // write data
   input  wire logic         hready,    // bus ready
   input  wire sodfj_apert_t apert,     // aperture words
   output logic [31:0]       hrdata,    // read data
   output logic              hreadyout, // slave ready
   output logic              hresp      // always okay
);
   ////////////////////////////////////////////////////////////////////
   // bus slave: one wait state on reads so data comes from a flop
   logic        ap_wr, ap_rd, rd_wait;     // data phase state
   logic        next_ap_wr, next_ap_rd, next_rd_wait;
   logic [7:0]  ap_addr, next_ap_addr;     // latched offset
   logic [31:0] next_hrdata;               // read mux
   logic        take;                      // address phase accepted
   // architectural state
   logic [31:0] sgpr [NUM_SGPR];           // general and special rows
   logic [63:0] lane_en, next_lane;        // lane enable mask
   logic [47:0] pc, next_pc;               // program counter
   logic [2:0]  ctrl_stack_ptr, next_csp;             // control stack pointer
   logic        scalar_cond_bit, next_scc;             // scalar_cond_bit
   logic [63:0] res, next_res;             // last decoded source
   sodfj_flag_t flags, next_flags;         // decode outcome flags
   sodfj_opnd_t opnd, next_opnd;           // operand codes
   sodfj_cmd_t  cmd_q, next_cmd_q;         // last command
   logic [31:0] data, next_data;           // write value / literal
   logic [15:0] simm, next_simm;           // fork word offset
   // combinational helpers
   sodfj_cmd_t  cmd;                       // command on hwdata
   logic        go;                        // command write data phase
   logic [7:0]  s;                         // source code
   logic [6:0]  sidx, a0, a1, jb;          // aligned indices
   logic [63:0] cond, m_pass, m_fail, src_val;
   logic [6:0]  n_pass, n_fail;            // lane counts
   logic [47:0] tgt;                       // fork target
   logic [31:0] w0, w1, w2, w3;            // stack entry words
   logic [3:0]  fk;                        // float table index
   logic        vector_cond_zero_flag, lane_mask_zero_flag;               // zero flags
   logic [3:0]  we;                        // array write enables
   logic [6:0]  wbase;                     // first row written
   logic [3:0][31:0] wd;                   // array write words
   logic [31:0] join_ref;                  // pointer saved at fork time

   // register read with lane mask aliasing and row 125 reading zero
   function automatic logic [31:0] sg_rd(input logic [6:0] i);
      if (i == C_LANE_ENABLE_LOW[6:0]) return lane_en[31:0];
      if (i == C_LANE_ENABLE_HIGH[6:0]) return lane_en[63:32];
      if (i == C_RSVD[6:0])    return 32'h0;
      return sgpr[i];
   endfunction

   ////////////////////////////////////////////////////////////////////
   // bus phase tracking and read data
   assign take      = hsel & htrans[1] & hready;
   assign hreadyout = ~(ap_rd & ~rd_wait);
   assign hresp     = 1'b0;
   always_comb begin
      next_ap_wr   = hready ? (take & hwrite) : ap_wr;
      next_ap_rd   = hready ? (take & ~hwrite) : ap_rd;
      next_ap_addr = take ? haddr[7:0] : ap_addr;
      next_rd_wait = ap_rd & ~rd_wait;
      next_hrdata  = hrdata;
      if (ap_rd & ~rd_wait) begin
         case (ap_addr)
            A_CMD:    next_hrdata = cmd_q;
            A_OPND:   next_hrdata = opnd;
            A_DATA:   next_hrdata = data;
            A_SIMM:   next_hrdata = {16'h0, simm};
            A_RES_LO: next_hrdata = res[31:0];
            A_RES_HI: next_hrdata = res[63:32];
            A_STAT:   next_hrdata = {22'h0, flags, lane_mask_zero_flag, vector_cond_zero_flag, scalar_cond_bit, ctrl_stack_ptr};
            A_PC_LO:  next_hrdata = pc[31:0];
            A_PC_HI:  next_hrdata = {16'h0, pc[47:32]};
            default:  next_hrdata = 32'h0;  // unmapped reads zero
         endcase
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr <= 1'b0; ap_rd <= 1'b0; rd_wait <= 1'b0;
         ap_addr <= 8'h00; hrdata <= 32'h0;
      end else if (ce) begin
         ap_wr <= next_ap_wr; ap_rd <= next_ap_rd; rd_wait <= next_rd_wait;
         ap_addr <= next_ap_addr; hrdata <= next_hrdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // operand decode, fork and join
   assign vector_cond_zero_flag  = ~|{sgpr[C_VECTOR_COND_HIGH], sgpr[C_VECTOR_COND_LOW]};
   assign lane_mask_zero_flag = ~|lane_en;
   always_comb begin
      cmd  = sodfj_cmd_t'(hwdata);
      go   = ap_wr && (ap_addr == A_CMD);
      s    = opnd.src;
      // pairs use the even row; odd codes are the program's fault
      sidx = cmd.wide ? {s[6:1], 1'b0} : s[6:0];
      a0   = {opnd.arg0[6:1], 1'b0};
      a1   = {opnd.arg1[6:1], 1'b0};
      fk   = 4'(s - C_FP_FIRST);
      next_flags = '0;
      // source decode
      if (s < C_ZERO && s != C_RSVD) begin
         src_val = {cmd.wide ? sg_rd(sidx | 7'h1) : 32'h0, sg_rd(sidx)};
      end else if (s == C_ZERO) begin
         src_val = 64'h0;
      end else if (s > C_ZERO && s <= C_POS_LAST) begin
         src_val = {56'h0, 8'(s - C_ZERO)};
      end else if (s > C_POS_LAST && s <= C_NEG_LAST) begin
         src_val = {{56{1'b1}}, 8'(C_POS_LAST - s)};
      end else if (s >= C_APT_LO && s <= C_WAVE_ID) begin
         case (s - C_APT_LO)
            8'h00:   src_val = {32'h0, apert.shared_aperture_base};
            8'h01:   src_val = {32'h0, apert.shared_aperture_limit};
            8'h02:   src_val = {32'h0, apert.private_aperture_base};
            8'h03:   src_val = {32'h0, apert.private_aperture_limit};
            default: src_val = {32'h0, apert.exit_wave_id};
         endcase
      end else if (s >= C_FP_FIRST && s <= C_FP_LAST) begin
         src_val = cmd.dbl
            ? {FP_DHI[fk], (fk == FP_INV_IDX) ? FP_INV_DLO : 32'h0}
            : {32'h0, FP_SGL[fk]};
      end else if (s == C_VECTOR_COND_ZERO_FLAG) begin
         src_val = {63'h0, vector_cond_zero_flag};
      end else if (s == C_LANE_MASK_ZERO_FLAG) begin
         src_val = {63'h0, lane_mask_zero_flag};
      end else if (s == C_SCC) begin
         src_val = {63'h0, scalar_cond_bit};
      end else if (s == C_LIT && cmd.fmt == FMT_OTHER) begin
         src_val = {32'h0, data};
         next_flags.lit_used = 1'b1;
      end else if (s == C_LIT) begin
         // short formats carry no literal; the code reads as zero
         src_val = 64'h0;
         next_flags.bad_lit = 1'b1;
      end else begin
         src_val = {cmd.wide ? sgpr[1] : 32'h0, sgpr[0]};
         next_flags.src_sub = 1'b1;
      end
      // fork masks and target
      cond   = {sg_rd(a0 | 7'h1), sg_rd(a0)};
      m_pass = cond & lane_en;
      m_fail = ~cond & lane_en;
      n_pass = 7'($countones(m_pass));
      n_fail = 7'($countones(m_fail));
      w0 = sg_rd(a1 | 7'h1);
      tgt = (cmd.op == OP_GFORK) ? {w0[15:0], sg_rd(a1)}
          : pc + PC_STEP + {{30{simm[15]}}, simm, 2'b00};
      // join reads the entry below the pointer
      jb = 7'({ctrl_stack_ptr - 3'h1, 2'b00});
      w0 = sg_rd(jb);
      w1 = sg_rd(jb + 7'h1);
      w2 = sg_rd(jb + 7'h2);
      w3 = sg_rd(jb + 7'h3);
      join_ref = sg_rd(opnd.arg0);
      // defaults hold state
      next_pc = pc; next_csp = ctrl_stack_ptr; next_lane = lane_en; next_scc = scalar_cond_bit;
      next_res = res; next_opnd = opnd; next_cmd_q = cmd_q;
      next_data = data; next_simm = simm;
      we = 4'h0; wbase = 7'h0; wd = '0;
      if (!go) next_flags = flags;
      if (ap_wr) begin
         case (ap_addr)
            A_OPND:  next_opnd = sodfj_opnd_t'(hwdata);
            A_DATA:  next_data = hwdata;
            A_SIMM:  next_simm = hwdata[15:0];
            A_PC_LO: next_pc = {pc[47:32], hwdata};
            A_PC_HI: next_pc = {hwdata[15:0], pc[31:0]};
            default: next_pc = pc;   // command and read-only offsets
         endcase
      end
      if (go) begin
         next_cmd_q = cmd;
         case (cmd.op)
            OP_READ: next_res = src_val;
            OP_WRITE: begin
               next_scc = cmd.scc_in;
               if (cmd.save) next_lane[31:0] = data;
               if (opnd.dst == C_RSVD[6:0]) begin
                  next_flags.dst_drop = 1'b1;
               end else if (opnd.dst == C_LANE_ENABLE_LOW[6:0]) begin
                  next_lane[31:0] = cmd.save ? lane_en[31:0] : data;
               end else if (opnd.dst == C_LANE_ENABLE_HIGH[6:0]) begin
                  next_lane[63:32] = cmd.save ? lane_en[31:0] : data;
               end else begin
                  we[0] = 1'b1;
                  wbase = opnd.dst;
                  wd[0] = cmd.save ? lane_en[31:0] : data;
               end
            end
            OP_IFORK, OP_GFORK: begin
               if (m_pass == lane_en) begin
                  next_pc = tgt;
               end else if (m_fail == lane_en) begin
                  next_pc = pc + PC_STEP;
               end else begin
                  we = 4'hf;
                  wbase = 7'({ctrl_stack_ptr, 2'b00});
                  next_csp = ctrl_stack_ptr + 3'h1;
                  if (n_fail < n_pass) begin
                     next_lane = m_fail;
                     wd = {m_pass, 16'h0, tgt};
                     next_pc = pc + PC_STEP;
                  end else begin
                     next_lane = m_pass;
                     wd = {m_fail, 16'h0, 48'(pc + PC_STEP)};
                     next_pc = tgt;
                  end
               end
            end
            OP_JOIN: begin
               // row arg0 holds the pointer saved at fork time
               if (ctrl_stack_ptr == join_ref[2:0]) begin
                  next_pc = pc + PC_STEP;
               end else begin
                  next_csp = ctrl_stack_ptr - 3'h1;
                  next_pc = {w1[15:0], w0};
                  next_lane = {w3, w2};
               end
            end
            OP_LAUNCH: next_csp = 3'h0;
            default: next_csp = ctrl_stack_ptr;
         endcase
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc <= 48'h0; ctrl_stack_ptr <= 3'h0; lane_en <= 64'h0; scalar_cond_bit <= 1'b0;
         res <= 64'h0; flags <= '0; opnd <= '0; cmd_q <= '0;
         data <= 32'h0; simm <= 16'h0;
      end else if (ce) begin
         pc <= next_pc; ctrl_stack_ptr <= next_csp; lane_en <= next_lane;
         scalar_cond_bit <= next_scc; res <= next_res; flags <= next_flags;
         opnd <= next_opnd; cmd_q <= next_cmd_q;
         data <= next_data; simm <= next_simm;
      end
   end
   // register array: up to four rows per edge, no reset
   always_ff @(posedge hclk) begin
      if (ce) begin
         for (int k = 0; k < 4; k++) begin
            if (we[k]) sgpr[7'(wbase + 7'(k))] <= wd[k];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   a_launch_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && go && cmd.op == OP_LAUNCH |=> ctrl_stack_ptr == 3'h0)
      else $error("launch did not clear stack pointer");
   a_push_incr: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && go && (cmd.op == OP_IFORK || cmd.op == OP_GFORK) && we[0]
      |=> ctrl_stack_ptr == $past(ctrl_stack_ptr) + 3'h1)
      else $error("push did not bump stack pointer");
   a_uniform_nopush: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && go && cmd.op == OP_IFORK && m_fail == lane_en && m_pass != lane_en
      |=> ctrl_stack_ptr == $past(ctrl_stack_ptr) && pc == $past(pc) + PC_STEP)
      else $error("uniform failing fork misbehaved");
   a_fewer_first: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && go && (cmd.op == OP_IFORK || cmd.op == OP_GFORK) && we[0]
      |=> 2 * $countones(lane_en) <= $countones($past(lane_en)))
      else $error("larger side ran first");
   a_join_pop: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && go && cmd.op == OP_JOIN && ctrl_stack_ptr != join_ref[2:0]
      |=> ctrl_stack_ptr == $past(ctrl_stack_ptr) - 3'h1 && lane_en == $past({w3, w2})
          && pc == $past({w1[15:0], w0}))
      else $error("join did not pop entry");
   a_dst_drop: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && go && cmd.op == OP_WRITE && opnd.dst == C_RSVD[6:0]
      |-> we == 4'h0 ##1 flags.dst_drop && scalar_cond_bit == $past(cmd.scc_in))
      else $error("dropped write misbehaved");
   a_int_const: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && go && cmd.op == OP_READ && s > C_ZERO && s <= C_POS_LAST
      |=> res[7:0] + C_ZERO == $past(s) && res[63:8] == 56'h0)
      else $error("positive constant wrong");
   a_src_subst: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && go && cmd.op == OP_READ && !cmd.wide && s == C_RSVD
      |=> res[31:0] == $past(sgpr[0]) && flags.src_sub)
      else $error("out of range source not replaced");
   a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      ce && take && !hwrite ##1 ce |-> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
endmodule // sodfj_core
`default_nettype wire

// ==== pkg/sodfj_pkg.sv ====
// Purpose: constants and carrier types of the scalar operand decode and
//          fork/join sequencer
// Assumes: 32-bit AHB-Lite register bus, one wavefront
// Notes:   operand codes are 8 bits, destination codes 7 bits
package sodfj_pkg;
   // operand code map
   localparam logic [7:0] C_RSVD     = 8'h7d; // 125, never a register
   localparam logic [7:0] C_LANE_ENABLE_LOW  = 8'h7e; // lane_enable_low
   localparam logic [7:0] C_LANE_ENABLE_HIGH  = 8'h7f; // lane_enable_high
   localparam logic [7:0] C_ZERO     = 8'h80; // integer zero
   localparam logic [7:0] C_POS_LAST = 8'hc0; // integer 64
   localparam logic [7:0] C_NEG_LAST = 8'hd0; // integer -16
   localparam logic [7:0] C_APT_LO   = 8'heb; // shared_aperture_base
   localparam logic [7:0] C_WAVE_ID  = 8'hef; // ordered_exit_wave_id
   localparam logic [7:0] C_FP_FIRST = 8'hf0; // 0.5
   localparam logic [7:0] C_FP_LAST  = 8'hf8; // 1/(2*pi)
   localparam logic [7:0] C_VECTOR_COND_ZERO_FLAG     = 8'hfb; // vector_cond_zero_flag
   localparam logic [7:0] C_LANE_MASK_ZERO_FLAG    = 8'hfc; // lane_mask_zero_flag
   localparam logic [7:0] C_SCC      = 8'hfd; // scalar_cond_bit
   localparam logic [7:0] C_LIT      = 8'hff; // literal dword
   localparam logic [6:0] C_VECTOR_COND_LOW   = 7'h6a; // vector_cond_low
   localparam logic [6:0] C_VECTOR_COND_HIGH   = 7'h6b; // vector_cond_high
   localparam int         NUM_SGPR   = 126;   // array rows 0..125
   localparam logic [47:0] PC_STEP   = 48'h4; // one instruction dword
   localparam logic [3:0] FP_INV_IDX = 4'h8;  // index of 1/(2*pi)
   // float constants: single words and double high words
   localparam logic [31:0] FP_SGL [9] = '{32'h3f000000, 32'hbf000000,
      32'h3f800000, 32'hbf800000, 32'h40000000, 32'hc0000000,
      32'h40800000, 32'hc0800000, 32'h3e22f983};
   localparam logic [31:0] FP_DHI [9] = '{32'h3fe00000, 32'hbfe00000,
      32'h3ff00000, 32'hbff00000, 32'h40000000, 32'hc0000000,
      32'h40100000, 32'hc0100000, 32'h3fc45f30};
   localparam logic [31:0] FP_INV_DLO = 32'h6dc9c882;
   // register byte offsets
   localparam logic [7:0] A_CMD    = 8'h00;
   localparam logic [7:0] A_OPND   = 8'h04;
   localparam logic [7:0] A_DATA   = 8'h08;
   localparam logic [7:0] A_SIMM   = 8'h0c;
   localparam logic [7:0] A_RES_LO = 8'h10;
   localparam logic [7:0] A_RES_HI = 8'h14;
   localparam logic [7:0] A_STAT   = 8'h18;
   localparam logic [7:0] A_PC_LO  = 8'h1c;
   localparam logic [7:0] A_PC_HI  = 8'h20;
   typedef enum logic [2:0] {OP_NOP = 3'h0, OP_READ = 3'h1, OP_WRITE = 3'h2,
      OP_IFORK = 3'h3, OP_GFORK = 3'h4, OP_JOIN = 3'h5,
      OP_LAUNCH = 3'h6} sodfj_op_t;
   localparam logic [1:0] FMT_OTHER = 2'h0; // literal allowed
   localparam logic [1:0] FMT_PROG  = 2'h1; // prog_ctl_format
   localparam logic [1:0] FMT_IMM16 = 2'h2; // imm16_format
   typedef struct packed {
      logic [22:0] rsvd; logic scc_in; logic save; logic dbl; logic wide;
      logic [1:0]  fmt;  sodfj_op_t op;
   } sodfj_cmd_t;
   typedef struct packed {
      logic p3; logic [6:0] arg1; logic p2; logic [6:0] arg0;
      logic p1; logic [6:0] dst;  logic [7:0] src;
   } sodfj_opnd_t;
   typedef struct packed {
      logic dst_drop; logic src_sub; logic bad_lit; logic lit_used;
   } sodfj_flag_t;
   typedef struct packed {
      logic [31:0] shared_aperture_base; logic [31:0] shared_aperture_limit;
      logic [31:0] private_aperture_base; logic [31:0] private_aperture_limit;
      logic [31:0] exit_wave_id;
   } sodfj_apert_t;
endpackage

// ==== test/sodfj_wave_model.sv ====
// Purpose: far-side model, issue sequencer side of one wavefront
// Assumes: aperture words and exit id are static while a wave runs
// Notes:   values are arbitrary but distinct, so a swapped word shows
`timescale 1ns/1ps
`default_nettype none
module sodfj_wave_model
   import sodfj_pkg::*;
(
   output var sodfj_apert_t apert // aperture words and exit wave id
);
   // fixed words: a real sequencer only reloads these between waves
   assign apert = {32'h1000_0000, 32'h1fff_fff0, 32'h2000_0000,
                   32'h2fff_fff0, 32'h0000_0003};
endmodule // sodfj_wave_model
`default_nettype wire

// ==== test/testbench.sv ====
// Purpose: self-checking bench of the operand decode and fork/join block
// Assumes: one AHB-Lite master, one wait state on reads, none on writes
// Notes:   random data from a fixed xorshift seed
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sodfj_pkg::*;
   logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp; // bus
   logic [1:0]   htrans;                  // transfer type
   logic [2:0]   hsize;                   // always a word
   logic [31:0]  haddr, hwdata, hrdata;   // address and data
   sodfj_apert_t apert;                   // from the wave model
   logic         ce;                      // clock enable
   int           error_cnt, tests_run;    // tallies
   logic [31:0]  seed, q, v0;             // rng state, read data, row 0
   logic [6:0]   rows [6] = '{7'd0, 7'd5, 7'd101, 7'd102, 7'd106, 7'd124};
   sodfj_wave_model sodfj_wave_model_i (.apert(apert));
   // the one slave drives hready back to itself
   sodfj_core sodfj_core_i (.hclk(hclk), .hresetn(hresetn), .ce(ce),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .apert(apert),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // inline integers: 128 is zero, then 1..64, then -1..-16
   function automatic logic [31:0] ie(input int c);
      if (c <= 192) return 32'(c - 128);
      return 32'(192 - c);
   endfunction
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   // one single transfer; each phase held until hready is seen high
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
      do begin @(posedge hclk); n++; end
      while (hreadyout !== 1'b1 && n < 64);
      htrans <= 2'h0; hwdata <= d;
      do begin @(posedge hclk); n++; end
      while (hreadyout !== 1'b1 && n < 64);
      r = hrdata;
      if (n >= 64) begin error_cnt++; tally_and_finish(); end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] t;
      bus(1'b1, a, d, t);
   endtask
   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0, q);
   endtask
   task automatic op(input logic [31:0] o, c);
      wr(A_OPND, o);
      wr(A_CMD, c);
   endtask
   // write one destination row, scc_in set to s
   task automatic wrow(input logic [6:0] r, input logic [31:0] d,
                       input logic s);
      wr(A_DATA, d);
      op({17'h0, r, 8'h0}, {23'h0, s, 8'h02});
   endtask
   task automatic src(input logic [7:0] c, input logic [1:0] f);
      op({24'h0, c}, {27'h0, f, 3'h1});
      rd(A_RES_LO);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      hresetn = 1'b0; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; haddr = 32'h0; hwdata = 32'h0;
      ce = 1'b1;
      error_cnt = 0; tests_run = 0; seed = 32'h50; v0 = 32'h0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // condition rows are not reset: clear them so the flags are defined
      wrow(C_VECTOR_COND_LOW, 32'h0, 1'b0); wrow(C_VECTOR_COND_HIGH, 32'h0, 1'b0);
      rd(A_STAT); chk("stat", 32'h30, q);
      chk("hresp", 32'h0, {31'h0, hresp});
      src(C_VECTOR_COND_ZERO_FLAG, FMT_OTHER); chk("vector_cond_zero_flag", 32'h1, q);
      src(C_LANE_MASK_ZERO_FLAG, FMT_OTHER); chk("lane_mask_zero_flag", 32'h1, q);
      rd(8'h40); chk("unmapped", 32'h0, q);
      for (int c = 128; c <= 208; c++) begin
         src(8'(c), FMT_OTHER); chk("int", ie(c), q);
      end
      for (int c = 240; c <= 248; c++) begin
         src(8'(c), FMT_OTHER); chk("fp", FP_SGL[c-240], q);
      end
      // double precision 1/(2*pi) has a non-zero low word
      op({24'h0, C_FP_LAST}, 32'h41);
      rd(A_RES_LO); chk("fp_dlo", FP_INV_DLO, q);
      rd(A_RES_HI); chk("fp_dhi", FP_DHI[8], q);
      for (int k = 0; k < 5; k++) begin
         src(8'(235 + k), FMT_OTHER);
         chk("apert", apert[159-32*k -: 32], q);
      end
      // registers in both directions, random contents
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         if (i == 0) v0 = seed;
         wrow(rows[i], seed, 1'b0);
         src({1'b0, rows[i]}, FMT_OTHER); chk("row", seed, q);
      end
      seed = xs(seed);
      wr(A_DATA, seed);
      src(C_LIT, FMT_OTHER); chk("lit", seed, q);
      src(C_LIT, FMT_PROG); chk("lit_prog", 32'h0, q);
      src(C_LIT, FMT_IMM16); chk("lit_imm", 32'h0, q);
      src(C_RSVD, FMT_OTHER); chk("subst", v0, q);
      wrow(7'h7d, 32'h1234, 1'b1);
      src(C_SCC, FMT_OTHER); chk("scc", 32'h1, q);
      src(8'h0, FMT_OTHER); chk("dropped", v0, q);
      // divergent fork: 3 lanes pass, 5 fail, pass side first
      wrow(7'h7e, 32'hff, 1'b0); wrow(7'h7f, 32'h0, 1'b0);
      wrow(7'd10, 32'h7, 1'b0); wrow(7'd11, 32'h0, 1'b0);
      wrow(7'd20, 32'h0, 1'b0);
      wr(A_PC_LO, 32'h100); wr(A_PC_HI, 32'h0); wr(A_SIMM, 32'h10);
      op(32'h000a_0000, 32'h3);
      rd(A_PC_LO); chk("pc_fork", 32'h144, q);
      rd(A_STAT); chk("csp", 32'h1, q & 32'h7);
      src(8'h0, FMT_OTHER); chk("push_pc", 32'h104, q);
      src(8'h2, FMT_OTHER); chk("push_mask", 32'hf8, q);
      src(C_LANE_ENABLE_LOW, FMT_OTHER); chk("exec", 32'h7, q);
      // first join pops the other side, second continues
      op(32'h0014_0000, 32'h5);
      rd(A_PC_LO); chk("pc_pop", 32'h104, q);
      src(C_LANE_ENABLE_LOW, FMT_OTHER); chk("exec_pop", 32'hf8, q);
      op(32'h0014_0000, 32'h5);
      rd(A_PC_LO); chk("pc_join", 32'h108, q);
      // a write made while the clock enable is low must not land
      ce <= 1'b0;
      wr(A_PC_LO, 32'h0bad_0000);
      ce <= 1'b1;
      rd(A_PC_LO); chk("ce_hold", 32'h108, q);
      // uniform pass on register fork, then uniform fail
      wrow(7'd10, 32'hff, 1'b0);
      wrow(7'd30, 32'h2000, 1'b0); wrow(7'd31, 32'h1, 1'b0);
      op(32'h1e0a_0000, 32'h4);
      rd(A_PC_LO); chk("pc_gfork", 32'h2000, q);
      rd(A_PC_HI); chk("pc_gfork_hi", 32'h1, q);
      // 64-bit source from an even pair
      op({24'h0, 8'd30}, 32'h21);
      rd(A_RES_LO); chk("wide_lo", 32'h2000, q);
      rd(A_RES_HI); chk("wide_hi", 32'h1, q);
      wrow(7'd10, 32'h7, 1'b0);
      op(32'h000a_0000, 32'h3);
      rd(A_PC_LO); chk("pc_fail", 32'h2004, q);
      rd(A_STAT); chk("csp_none", 32'h0, q & 32'h7);
      // save to a dropped destination still loads the lane mask
      wr(A_DATA, 32'h0f);
      op({17'h0, 7'h7d, 8'h0}, 32'h82);
      src(C_LANE_ENABLE_LOW, FMT_OTHER); chk("save_lane", 32'h0f, q);
      // 3 pass, 1 fails: fail side first, target pushed, then launch
      op(32'h000a_0000, 32'h3);
      rd(A_PC_LO); chk("pc_step", 32'h2008, q);
      src(C_LANE_ENABLE_LOW, FMT_OTHER); chk("exec_fail", 32'h8, q);
      src(8'h0, FMT_OTHER); chk("push_tgt", 32'h2048, q);
      rd(A_STAT); chk("csp_push", 32'h1, q & 32'h7);
      op(32'h0, 32'h6);
      rd(A_STAT); chk("launch", 32'h0, q & 32'h7);
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
